// ===== verilog/bridge_config_header_regs.sv
/*
 * configuration header words 08h..1Ch of a reversible bridge, reached as a
 * classic wishbone slave. assumes straps hold steady through reset and a
 * master that holds its request until ack.
 */
// Operation
// - class code programming interface byte is read-only zero.
// - cache line bits 2 and 3 writable, select 4 and 8 dwords, reset 0.
// - cache line bits 4 and 5 writable, select 16 and 32 dwords, reset 0.
// - cache line bits 1:0 and 7:6 always read zero.
// - primary latency limit is byte 15:8 of word 0Ch in both modes.
// - forward mode: primary latency read-only, reset 00h.
// - reverse mode: primary latency writable, reset 00h pci or 40h pci-x.
// - secondary latency writable in forward mode, read-only 00h in reverse.
// - header bit 23 and bits 31:24 read zero.
// - io base bits 1:0 and io limit bits 9:8 read 01.
// - io base bits 7:4 writable reset 0, bits 3:2 read zero.
// - io limit bits 15:12 writable reset 0, bits 11:10 read zero.
`timescale 1ns/1ps
module bridge_config_header_regs
	import bridge_cfg_pkg::*;
#(
	// arbitrary neutral value
	parameter logic [7:0] REVISION_LEVEL = 8'h01
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// mode straps
	input wire logic i_reverse_mode,
	input wire logic i_pri_pcix,
	input wire logic i_sec_pcix,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// configuration to bridge logic
	output logic [7:0] o_cache_line_length,
	output logic [7:0] o_primary_latency_limit,
	output logic [7:0] o_secondary_latency_limit,
	output logic [7:0] o_upstream_bus_number,
	output logic [7:0] o_downstream_bus_number,
	output logic [7:0] o_highest_bus_number,
	output logic [7:0] o_io_window_base,
	output logic [7:0] o_io_window_limit
);
	slave_state_e state_q, state_d;
	logic [31:0] rdat_q, rdat_d;
	logic ack_q, ack_d;
	logic reverse_q, pri_pcix_q, sec_pcix_q, strap_valid_q;
	logic req_go, wr_go, init_go;
	logic [7:0] word_adr;
	logic [7:0] pri_lat_init, sec_lat_init;
	logic wr_cache, wr_pri_lat, wr_sec_lat;
	logic wr_up_bus, wr_down_bus, wr_high_bus;
	logic wr_io_base, wr_io_limit;
	logic [7:0] io_base_rd, io_limit_rd;
	logic [31:0] rd_mux;

	mode_strap_latch u_straps (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_reverse_mode(i_reverse_mode),
		.i_pri_pcix(i_pri_pcix),
		.i_sec_pcix(i_sec_pcix),
		.o_reverse_q(reverse_q),
		.o_pri_pcix_q(pri_pcix_q),
		.o_sec_pcix_q(sec_pcix_q),
		.o_valid_q(strap_valid_q)
	);

	// request decode; low address bits ignored, sel picks bytes
	always_comb begin
		word_adr = {i_wb_adr[7:2], 2'b00};
		req_go = (state_q == ST_IDLE) && i_wb_cyc && i_wb_stb;
		wr_go = req_go && i_wb_we;
		init_go = (state_q == ST_INIT) && strap_valid_q;
	end

	// latency defaults depend on the straps, so they load after capture
	always_comb begin
		pri_lat_init = LAT_PCI_RST;
		sec_lat_init = LAT_PCI_RST;
		if (reverse_q && pri_pcix_q) begin
			pri_lat_init = LAT_PCIX_RST;
		end
		if (!reverse_q && sec_pcix_q) begin
			sec_lat_init = LAT_PCIX_RST;
		end
	end

	// write strobes per byte; read-only fields have none
	always_comb begin
		wr_cache = wr_go && (word_adr == OFF_MISC) && i_wb_sel[0];
		wr_pri_lat = wr_go && (word_adr == OFF_MISC) && i_wb_sel[1] && reverse_q;
		wr_up_bus = wr_go && (word_adr == OFF_BUSNUM) && i_wb_sel[0];
		wr_down_bus = wr_go && (word_adr == OFF_BUSNUM) && i_wb_sel[1];
		wr_high_bus = wr_go && (word_adr == OFF_BUSNUM) && i_wb_sel[2];
		wr_sec_lat = wr_go && (word_adr == OFF_BUSNUM) && i_wb_sel[3] && !reverse_q;
		wr_io_base = wr_go && (word_adr == OFF_IOWIN) && i_wb_sel[0];
		wr_io_limit = wr_go && (word_adr == OFF_IOWIN) && i_wb_sel[1];
	end

	// bits 5:2 only; the rest of the byte is masked off
	cfg_field_reg #(.MASK(CACHE_LINE_MASK)) u_cache_line (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_init(1'b0),
		.i_init_val(BYTE_RST),
		.i_wr(wr_cache),
		.i_wdat(i_wb_dat[7:0]),
		.o_val_q(o_cache_line_length)
	);

	cfg_field_reg #(.MASK(FULL_BYTE_MASK)) u_pri_lat (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_init(init_go),
		.i_init_val(pri_lat_init),
		.i_wr(wr_pri_lat),
		.i_wdat(i_wb_dat[15:8]),
		.o_val_q(o_primary_latency_limit)
	);

	cfg_field_reg #(.MASK(FULL_BYTE_MASK)) u_sec_lat (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_init(init_go),
		.i_init_val(sec_lat_init),
		.i_wr(wr_sec_lat),
		.i_wdat(i_wb_dat[31:24]),
		.o_val_q(o_secondary_latency_limit)
	);

	cfg_field_reg #(.MASK(FULL_BYTE_MASK)) u_up_bus (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_init(1'b0),
		.i_init_val(BYTE_RST),
		.i_wr(wr_up_bus),
		.i_wdat(i_wb_dat[7:0]),
		.o_val_q(o_upstream_bus_number)
	);

	cfg_field_reg #(.MASK(FULL_BYTE_MASK)) u_down_bus (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_init(1'b0),
		.i_init_val(BYTE_RST),
		.i_wr(wr_down_bus),
		.i_wdat(i_wb_dat[15:8]),
		.o_val_q(o_downstream_bus_number)
	);

	cfg_field_reg #(.MASK(FULL_BYTE_MASK)) u_high_bus (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_init(1'b0),
		.i_init_val(BYTE_RST),
		.i_wr(wr_high_bus),
		.i_wdat(i_wb_dat[23:16]),
		.o_val_q(o_highest_bus_number)
	);

	cfg_field_reg #(.MASK(IO_WIN_MASK)) u_io_base (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_init(1'b0),
		.i_init_val(BYTE_RST),
		.i_wr(wr_io_base),
		.i_wdat(i_wb_dat[7:0]),
		.o_val_q(o_io_window_base)
	);

	cfg_field_reg #(.MASK(IO_WIN_MASK)) u_io_limit (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_init(1'b0),
		.i_init_val(BYTE_RST),
		.i_wr(wr_io_limit),
		.i_wdat(i_wb_dat[15:8]),
		.o_val_q(o_io_window_limit)
	);

	// read view; addressing capability bits are merged in here
	always_comb begin
		io_base_rd = {o_io_window_base[7:4], IO_RSVD_VAL, IO_ADDR32_VAL};
		io_limit_rd = {o_io_window_limit[7:4], IO_RSVD_VAL, IO_ADDR32_VAL};
		case (word_adr)
			OFF_CLASS: begin
				rd_mux = {BASE_CLASS_VAL, SUB_CLASS_VAL, PROG_IF_VAL, REVISION_LEVEL};
			end
			OFF_MISC: begin
				rd_mux = {HDR_UPPER_VAL, MULTI_FUNC_VAL, HDR_LAYOUT_VAL,
					o_primary_latency_limit, o_cache_line_length};
			end
			OFF_BUSNUM: begin
				rd_mux = {o_secondary_latency_limit, o_highest_bus_number,
					o_downstream_bus_number, o_upstream_bus_number};
			end
			OFF_IOWIN: begin
				rd_mux = {16'h0000, io_limit_rd, io_base_rd};
			end
			// reserved words 10h..17h and everything unmapped read zero
			default: begin
				rd_mux = UNMAPPED_DATA;
			end
		endcase
	end

	// one wait state: ack one cycle after the request is seen, then drop
	always_comb begin
		state_d = state_q;
		ack_d = 1'b0;
		rdat_d = rdat_q;
		case (state_q)
			ST_INIT: begin
				if (strap_valid_q) begin
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (req_go) begin
					state_d = ST_ACK;
					ack_d = 1'b1;
					rdat_d = i_wb_we ? UNMAPPED_DATA : rd_mux;
				end
			end
			ST_ACK: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= ST_INIT;
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	always_comb begin
		o_wb_ack = ack_q;
		o_wb_dat = rdat_q;
	end

	// checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_rd(logic [7:0] off);
		req_go && !i_wb_we && (word_adr == off);
	endsequence

	sequence s_wr(logic [7:0] off, int lane);
		req_go && i_wb_we && (word_adr == off) && i_wb_sel[lane];
	endsequence

	a_prog_if_zero: assert property (s_rd(OFF_CLASS) |=> o_wb_ack && o_wb_dat[15:8] == 8'h00)
		else $error("programming interface byte not zero");

	a_cache_low_bits: assert property (s_wr(OFF_MISC, 0) |=>
		o_cache_line_length[3:2] == $past(i_wb_dat[3:2]))
		else $error("cache line bits 3:2 not written");

	a_cache_high_bits: assert property (s_wr(OFF_MISC, 0) |=>
		o_cache_line_length[5:4] == $past(i_wb_dat[5:4]))
		else $error("cache line bits 5:4 not written");

	a_cache_unused_zero: assert property (s_rd(OFF_MISC) |=>
		o_wb_dat[1:0] == 2'h0 && o_wb_dat[7:6] == 2'h0)
		else $error("unsupported cache line bits not zero");

	a_pri_lat_read: assert property (s_rd(OFF_MISC) |=>
		o_wb_dat[15:8] == o_primary_latency_limit)
		else $error("primary latency readback wrong");

	a_pri_lat_locked: assert property (s_wr(OFF_MISC, 1) ##0 !reverse_q |=>
		$stable(o_primary_latency_limit))
		else $error("primary latency written in forward mode");

	a_pri_lat_init: assert property (init_go && reverse_q && pri_pcix_q |=>
		o_primary_latency_limit == 8'h40 && state_q == ST_IDLE)
		else $error("primary latency pci-x default wrong");

	a_sec_lat_locked: assert property (s_wr(OFF_BUSNUM, 3) ##0 reverse_q |=>
		$stable(o_secondary_latency_limit))
		else $error("secondary latency written in reverse mode");

	a_header_upper: assert property (s_rd(OFF_MISC) |=> o_wb_dat[31:23] == 9'h000)
		else $error("header upper bits not zero");

	a_io_addr32: assert property (s_rd(OFF_IOWIN) |=>
		o_wb_dat[1:0] == 2'h1 && o_wb_dat[9:8] == 2'h1)
		else $error("io addressing field not 01");

	a_io_base_rsvd: assert property (s_rd(OFF_IOWIN) |=>
		o_wb_dat[3:2] == 2'h0 && o_wb_dat[7:4] == o_io_window_base[7:4])
		else $error("io base readback wrong");

	a_io_limit_rsvd: assert property (s_rd(OFF_IOWIN) |=>
		o_wb_dat[11:10] == 2'h0 && o_wb_dat[15:12] == o_io_window_limit[7:4])
		else $error("io limit readback wrong");

	a_bus_num_write: assert property (s_wr(OFF_BUSNUM, 0) |=>
		o_upstream_bus_number == $past(i_wb_dat[7:0]))
		else $error("bus number byte not written");

	a_rsvd_zero: assert property ((s_rd(OFF_RSVD0) or s_rd(OFF_RSVD1)) |=>
		o_wb_ack && o_wb_dat == 32'h0000_0000 ##1 !o_wb_ack)
		else $error("reserved word not zero");

	// forward defaults: primary stays 00h whatever the primary bus runs
	a_pri_lat_fwd_init: assert property (init_go && !reverse_q |=>
		o_primary_latency_limit == 8'h00)
		else $error("primary latency forward default wrong");

	a_sec_lat_init: assert property (init_go && !reverse_q && sec_pcix_q |=>
		o_secondary_latency_limit == 8'h40)
		else $error("secondary latency pci-x default wrong");

	a_sec_lat_rev_init: assert property (init_go && reverse_q |=>
		o_secondary_latency_limit == 8'h00)
		else $error("secondary latency reverse default wrong");

	a_cache_unused_store: assert property (s_wr(OFF_MISC, 0) |=>
		o_cache_line_length[1:0] == 2'h0 && o_cache_line_length[7:6] == 2'h0)
		else $error("unsupported cache line bits stored");

	a_io_base_write: assert property (s_wr(OFF_IOWIN, 0) |=>
		o_io_window_base == ($past(i_wb_dat[7:0]) & 8'hF0))
		else $error("io base window not written");

	a_io_limit_write: assert property (s_wr(OFF_IOWIN, 1) |=>
		o_io_window_limit == ($past(i_wb_dat[15:8]) & 8'hF0))
		else $error("io limit window not written");

	a_high_bus_write: assert property (s_wr(OFF_BUSNUM, 2) |=>
		o_highest_bus_number == $past(i_wb_dat[23:16]))
		else $error("highest bus number not written");
endmodule // bridge_config_header_regs

// ===== verilog/bridge_cfg_pkg.sv
/*
 * constants for the bridge configuration header block, offsets 08h..1Fh:
 * word offsets, field masks, reset values, fixed read-only fields, states.
 * assumes 32-bit configuration words addressed by byte on a wishbone bus.
 */
package bridge_cfg_pkg;
	// word byte offsets
	localparam logic [7:0] OFF_CLASS = 8'h08;
	localparam logic [7:0] OFF_MISC = 8'h0C;
	localparam logic [7:0] OFF_RSVD0 = 8'h10;
	localparam logic [7:0] OFF_RSVD1 = 8'h14;
	localparam logic [7:0] OFF_BUSNUM = 8'h18;
	localparam logic [7:0] OFF_IOWIN = 8'h1C;
	// fixed read-only fields
	localparam logic [7:0] PROG_IF_VAL = 8'h00;
	localparam logic [7:0] SUB_CLASS_VAL = 8'h04;
	localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
	localparam logic [6:0] HDR_LAYOUT_VAL = 7'h01;
	localparam logic MULTI_FUNC_VAL = 1'b0;
	localparam logic [7:0] HDR_UPPER_VAL = 8'h00;
	localparam logic [1:0] IO_ADDR32_VAL = 2'h1;
	localparam logic [1:0] IO_RSVD_VAL = 2'h0;
	// writable bit masks
	localparam logic [7:0] CACHE_LINE_MASK = 8'h3C;
	localparam logic [7:0] FULL_BYTE_MASK = 8'hFF;
	localparam logic [7:0] IO_WIN_MASK = 8'hF0;
	// reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] LAT_PCI_RST = 8'h00;
	localparam logic [7:0] LAT_PCIX_RST = 8'h40;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// slave states, one-hot
	typedef enum logic [2:0] {
		ST_INIT = 3'h1,
		ST_IDLE = 3'h2,
		ST_ACK = 3'h4
	} slave_state_e;
endpackage

// ===== verilog/mode_strap_latch.sv
/*
 * captures the bridge direction and bus mode straps once after reset.
 * assumes straps are steady around reset release.
 */
`timescale 1ns/1ps
module mode_strap_latch (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// straps
	input wire logic i_reverse_mode,
	input wire logic i_pri_pcix,
	input wire logic i_sec_pcix,
	// latched
	output logic o_reverse_q,
	output logic o_pri_pcix_q,
	output logic o_sec_pcix_q,
	output logic o_valid_q
);
	logic reverse_d, pri_d, sec_d, valid_d;

	// taken only on the first edge, so a strap glitch later is harmless
	always_comb begin
		reverse_d = o_valid_q ? o_reverse_q : i_reverse_mode;
		pri_d = o_valid_q ? o_pri_pcix_q : i_pri_pcix;
		sec_d = o_valid_q ? o_sec_pcix_q : i_sec_pcix;
		valid_d = 1'b1;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reverse_q <= 1'b0;
			o_pri_pcix_q <= 1'b0;
			o_sec_pcix_q <= 1'b0;
			o_valid_q <= 1'b0;
		end else begin
			o_reverse_q <= reverse_d;
			o_pri_pcix_q <= pri_d;
			o_sec_pcix_q <= sec_d;
			o_valid_q <= valid_d;
		end
	end
endmodule // mode_strap_latch

// ===== verilog/cfg_field_reg.sv
/*
 * one configuration byte with a mask of writable bits; masked bits read 0.
 * assumes the caller gates i_wr by address, byte lane and access mode.
 */
`timescale 1ns/1ps
module cfg_field_reg #(
	parameter logic [7:0] MASK = 8'hFF
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// load
	input wire logic i_init,
	input wire logic [7:0] i_init_val,
	input wire logic i_wr,
	input wire logic [7:0] i_wdat,
	// value
	output logic [7:0] o_val_q
);
	logic [7:0] val_d;

	always_comb begin
		val_d = o_val_q;
		if (i_init) begin
			val_d = i_init_val & MASK;
		end else if (i_wr) begin
			val_d = i_wdat & MASK;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_val_q <= 8'h00;
		end else begin
			o_val_q <= val_d;
		end
	end
endmodule // cfg_field_reg

// ===== tb/bridge_config_header_regs_bench.sv
/*
 * self-checking bench for the bridge configuration header block.
 * assumes a one-cycle ack slave on classic wishbone and straps held through reset.
 */
`timescale 1ns/1ps
module bridge_config_header_regs_bench;
	import bridge_cfg_pkg::*;
	// arbitrary revision value
	localparam logic [7:0] REV = 8'h5A;
	logic i_core_clk, i_rstn, i_reverse_mode, i_pri_pcix, i_sec_pcix;
	logic i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
	logic [7:0] i_wb_adr;
	logic [3:0] i_wb_sel;
	logic [31:0] i_wb_dat, o_wb_dat, rd;
	logic [7:0] cache_len, pri_lat, sec_lat, up_bus, dn_bus, hi_bus, io_base, io_lim;
	logic [7:0] pri_rst, sec_rst;
	logic [2:0] modes [4];
	int n_mismatch, compares;

	bridge_config_header_regs #(.REVISION_LEVEL(REV)) dut (
		.i_core_clk(i_core_clk), .i_rstn(i_rstn),
		.i_reverse_mode(i_reverse_mode), .i_pri_pcix(i_pri_pcix), .i_sec_pcix(i_sec_pcix),
		.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
		.i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
		.o_cache_line_length(cache_len), .o_primary_latency_limit(pri_lat),
		.o_secondary_latency_limit(sec_lat), .o_upstream_bus_number(up_bus),
		.o_downstream_bus_number(dn_bus), .o_highest_bus_number(hi_bus),
		.o_io_window_base(io_base), .o_io_window_limit(io_lim)
	);

	initial begin
		i_core_clk = 1'b0;
		forever #10 i_core_clk = ~i_core_clk;
	end

	task automatic report_and_stop();
		$display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// straps change only while reset is held
	task automatic do_reset(input logic [2:0] m);
		@(posedge i_core_clk);
		i_rstn <= 1'b0;
		{i_reverse_mode, i_pri_pcix, i_sec_pcix} <= m;
		repeat (20) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_core_clk);
	endtask

	// one classic cycle; read data taken at the ack edge only
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
			input logic [31:0] wd);
		int n;
		@(posedge i_core_clk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= we;
		i_wb_adr <= adr;
		i_wb_sel <= sel;
		i_wb_dat <= wd;
		for (n = 0; n < 50; n++) begin
			@(posedge i_core_clk);
			if (o_wb_ack === 1'b1) break;
		end
		rd = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		if (n == 50) begin
			n_mismatch++;
			$display("BAD at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
			report_and_stop();
		end
	endtask

	task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
		xfer(1'b0, adr, 4'hF, 32'h0000_0000);
		check(rd, exp);
	endtask

	initial begin
		i_rstn = 1'b0;
		{i_reverse_mode, i_pri_pcix, i_sec_pcix} = 3'h0;
		{i_wb_cyc, i_wb_stb, i_wb_we} = 3'h0;
		i_wb_adr = 8'h00;
		i_wb_sel = 4'h0;
		i_wb_dat = 32'h0000_0000;
		n_mismatch = 0;
		compares = 0;
		// {reverse, primary pci-x, secondary pci-x}
		modes = '{3'b011, 3'b000, 3'b111, 3'b101};
		for (int m = 0; m < 4; m++) begin
			do_reset(modes[m]);
			pri_rst = (modes[m][2] && modes[m][1]) ? LAT_PCIX_RST : LAT_PCI_RST;
			sec_rst = (!modes[m][2] && modes[m][0]) ? LAT_PCIX_RST : LAT_PCI_RST;
			rchk(OFF_CLASS, {8'h06, 8'h04, 8'h00, REV});
			rchk(OFF_MISC, {8'h00, 8'h01, pri_rst, 8'h00});
			rchk(OFF_BUSNUM, {sec_rst, 24'h00_0000});
			rchk(OFF_IOWIN, 32'h0000_0101);
			check({24'h0, pri_lat}, {24'h0, pri_rst});
			// read-only latency bytes must ignore an all-ones write
			xfer(1'b1, OFF_MISC, 4'hF, 32'hFFFF_FFFF);
			xfer(1'b1, OFF_BUSNUM, 4'hF, 32'hFFFF_FFFF);
			rchk(OFF_MISC, {16'h0001, modes[m][2] ? 8'hFF : pri_rst, 8'h3C});
			rchk(OFF_BUSNUM, {modes[m][2] ? sec_rst : 8'hFF, 24'hFF_FFFF});
			check({24'h0, sec_lat}, {24'h0, modes[m][2] ? sec_rst : 8'hFF});
			$display("test done: mode %0d", m);
		end
		// forward bridge, detailed field work
		do_reset(3'b000);
		for (int b = 2; b < 6; b++) begin
			xfer(1'b1, OFF_MISC, 4'h1, 32'h0000_0001 << b);
			rchk(OFF_MISC, {24'h00_0100, 8'h01 << b});
			check({24'h0, cache_len}, {24'h0, 8'h01 << b});
		end
		xfer(1'b1, OFF_MISC, 4'h1, 32'h0000_00C3);
		rchk(OFF_MISC, 32'h0001_0000);
		$display("test done: cache line");
		xfer(1'b1, OFF_BUSNUM, 4'hF, 32'hA5C3_5A12);
		rchk(OFF_BUSNUM, 32'hA5C3_5A12);
		xfer(1'b1, OFF_BUSNUM, 4'h2, 32'hFFFF_7EFF);
		rchk(OFF_BUSNUM, 32'hA5C3_7E12);
		check({up_bus, dn_bus, hi_bus, sec_lat}, 32'h127E_C3A5);
		$display("test done: bus numbers");
		xfer(1'b1, OFF_IOWIN, 4'hF, 32'hFFFF_FFFF);
		rchk(OFF_IOWIN, 32'h0000_F1F1);
		check({16'h0, io_lim, io_base}, 32'h0000_F0F0);
		xfer(1'b1, OFF_IOWIN, 4'h2, 32'h0000_5A3C);
		rchk(OFF_IOWIN, 32'h0000_51F1);
		$display("test done: io window");
		xfer(1'b1, OFF_RSVD0, 4'hF, 32'hFFFF_FFFF);
		xfer(1'b1, OFF_RSVD1, 4'hF, 32'hFFFF_FFFF);
		rchk(OFF_RSVD0, 32'h0000_0000);
		rchk(OFF_RSVD1, 32'h0000_0000);
		rchk(8'h40, 32'h0000_0000);
		xfer(1'b1, OFF_CLASS, 4'hF, 32'hFFFF_FFFF);
		rchk(OFF_CLASS, {8'h06, 8'h04, 8'h00, REV});
		rchk(OFF_BUSNUM, 32'hA5C3_7E12);
		$display("test done: reserved and read-only");
		report_and_stop();
	end
endmodule // bridge_config_header_regs_bench
